// ===== core/dram_host.sv
// host controller for the 2M x 64 module: sequencer, refresh and register slave
`timescale 1ns/10ps
`include "dram_host_defines.svh"
// Operation
// - WE low before CAS falls gives an early write; data pins stay released.
// - WE falling after all read delays gives read-modify-write; cell data comes first.
// - Every write meets either early-write or full read-modify-write timing.
// - Each page-mode read-modify-write column cycle lasts at least 98 ns.
// - Page-mode WE falls at least 73 ns after CAS precharge begins.
// - In column-first refresh CAS stays low 18 ns after RAS falls.
// - In column-first refresh CAS falls at least 15 ns before RAS.
// - WE stays high 15 ns before and 8 ns after RAS falls in refresh.
// - CAS stays high 3 ns after RAS rises before a column-first refresh.
// - 2048 refresh cycles are issued within every 32 ms.
// - Info lines need pull-ups; the module drives low or leaves open.
// - Only the selected position's presence enable is asserted.
// - A grounded width bit anywhere makes the whole bank 64-bit.
// - After power-up wait 200 us, then eight refresh cycles before accesses.
module dram_host import dram_host_pkg::*; #(
	parameter int INIT_CYC = `INIT_CYC
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output dram_pins_t dram,
	input wire logic [63:0] dq_in,
	output logic [63:0] dq_out,
	output logic dq_oe,
	output logic [3:0] presence_detect_enable_n,
	input wire logic [7:0] module_info_bits,
	input wire logic bank_width_id_bit,
	input wire logic refresh_style_id_bit
);
	localparam int CAP = `CYC_MIN(`T_CAC_NS) + `SYNC_STAGES;
	localparam int WE_AT = CAP + `CYC_MIN(`T_OEZ_NS);
	localparam int RMW_END = WE_AT + `CYC_MIN(`T_CWL_NS);
	localparam int EW_END = `CYC_MIN(`T_CWL_NS);
	localparam int RAS_CYC = `CYC_MIN(`T_RAS_NS);
	localparam int CHR_CYC = `CYC_MIN(`COL_HOLD_IN_COL_FIRST_REFRESH_NS);
	localparam int RP_CYC = `CYC_MIN(`T_RP_NS);
	localparam int PRWC_CYC = `CYC_MIN(`PAGE_RMW_CYCLE_TIME_NS);
	localparam int CPW_CYC = `CYC_MIN(`WRITE_AFTER_COL_PRECHARGE_DELAY_NS);

	seq_state_t st_q;
	dram_pins_t pins_q;
	logic [3:0] cnt_q;
	logic [13:0] init_cnt_q;
	logic [3:0] init_left_q;
	logic wait_done, init_done, ref_req, ref_need, ref_done, accept, busy, hit;
	logic [10:0] ref_row, open_row_q;
	logic [63:0] dq_s1_q, dq_s2_q, dq_out_q, rdata_q, wdata_q;
	logic dq_oe_q, waitreq_q, go_q, pd_go_q, keep_q, cbr_q, pd_busy;
	logic [1:0] op_q, slot_q, ids;
	logic [7:0] mask_q, info;
	logic [20:0] addr_q;
	logic [31:0] rd_d, readdata_q;
	logic wr_take;

	function automatic logic [63:0] merge_bytes(input logic [63:0] old_d,
		input logic [63:0] new_d, input logic [7:0] mask);
		logic [63:0] m;
		m = old_d;
		for (int i = 0; i < 8; i++)
			if (mask[i])
				m[i*8 +: 8] = new_d[i*8 +: 8];
		return m;
	endfunction : merge_bytes

	refresh_timer u_refresh (
		.mclk(mclk),
		.reset_n(reset_n),
		.done(ref_done),
		.req(ref_req),
		.row(ref_row)
	);

	presence_reader u_presence (
		.mclk(mclk),
		.reset_n(reset_n),
		.start(pd_go_q),
		.slot(slot_q),
		.module_info_bits(module_info_bits),
		.id_bits({refresh_style_id_bit, bank_width_id_bit}),
		.presence_detect_enable_n(presence_detect_enable_n),
		.info(info),
		.ids(ids),
		.busy(pd_busy)
	);

	assign dram = pins_q;
	assign dq_out = dq_out_q;
	assign dq_oe = dq_oe_q;
	assign avs_readdata = readdata_q;
	assign avs_waitrequest = waitreq_q;

	assign wait_done = (init_cnt_q == 14'(INIT_CYC));
	assign init_done = wait_done && (init_left_q == 4'h0);
	assign ref_need = ref_req || (wait_done && init_left_q != 4'h0);
	assign ref_done = (st_q == S_CBR_RAS || st_q == S_ROR) && cnt_q == 4'(RAS_CYC - 1);
	assign hit = (open_row_q == addr_q[`ADDR_ROW]);
	assign accept = go_q && !ref_need && init_done &&
		(st_q == S_IDLE || (st_q == S_OPEN && hit));
	assign busy = go_q || !(st_q == S_IDLE || st_q == S_OPEN) || !init_done;
	assign wr_take = avs_write && !waitreq_q;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			init_cnt_q <= 14'h0000;
			init_left_q <= `INIT_REFS;
		end else begin
			if (!wait_done)
				init_cnt_q <= init_cnt_q + 14'h0001;
			if (ref_done && init_left_q != 4'h0)
				init_left_q <= init_left_q - 4'h1;
		end
	end

	// data pins cross from the module through two stages before capture
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dq_s1_q <= 64'h0;
			dq_s2_q <= 64'h0;
		end else begin
			dq_s1_q <= dq_in;
			dq_s2_q <= dq_s1_q;
		end
	end

	// one wait cycle per access, then the answer for exactly one edge
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			waitreq_q <= 1'b1;
			readdata_q <= 32'h0;
		end else begin
			waitreq_q <= !(avs_read || avs_write) || !waitreq_q;
			if (avs_read && waitreq_q)
				readdata_q <= rd_d;
		end
	end

	always_comb begin
		rd_d = 32'h0;
		case (avs_address)
			`REG_CTRL: rd_d = {16'h0, mask_q, slot_q, 1'b0, cbr_q, keep_q, op_q, go_q};
			`REG_ADDR: rd_d = {11'h0, addr_q};
			`REG_WDLO: rd_d = wdata_q[31:0];
			`REG_WDHI: rd_d = wdata_q[63:32];
			`REG_RDLO: rd_d = rdata_q[31:0];
			`REG_RDHI: rd_d = rdata_q[63:32];
			// a low width bit from any module marks the bank as 64-bit
			`REG_STATUS: rd_d = {8'h0, info, 6'h0, ids, 3'h0, ~ids[0], pd_busy,
				st_q == S_OPEN, init_done, busy};
			default: rd_d = 32'h0;
		endcase
	end

	// settings are frozen while an access runs so it cannot change mid-cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			go_q <= 1'b0;
			pd_go_q <= 1'b0;
			op_q <= OP_READ;
			keep_q <= 1'b0;
			cbr_q <= 1'b1;
			slot_q <= 2'h0;
			mask_q <= 8'hFF;
			addr_q <= 21'h0;
			wdata_q <= 64'h0;
		end else begin
			pd_go_q <= 1'b0;
			if (accept)
				go_q <= 1'b0;
			if (wr_take && avs_address == `REG_CTRL) begin
				if (!busy) begin
					go_q <= avs_writedata[`CTRL_GO] && avs_writedata[`CTRL_OP] != 2'h3;
					op_q <= avs_writedata[`CTRL_OP];
					keep_q <= avs_writedata[`CTRL_KEEP];
					cbr_q <= avs_writedata[`CTRL_CBR];
					mask_q <= avs_writedata[`CTRL_MASK];
				end
				if (!pd_busy) begin
					pd_go_q <= avs_writedata[`CTRL_PD_GO];
					slot_q <= avs_writedata[`CTRL_PD_SLOT];
				end
			end
			if (wr_take && avs_address == `REG_ADDR && !busy)
				addr_q <= avs_writedata[20:0];
			if (wr_take && avs_address == `REG_WDLO && !busy)
				wdata_q[31:0] <= avs_writedata;
			if (wr_take && avs_address == `REG_WDHI && !busy)
				wdata_q[63:32] <= avs_writedata;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= S_INIT;
			cnt_q <= 4'h0;
			pins_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 11'h000};
			dq_oe_q <= 1'b0;
			dq_out_q <= 64'h0;
			rdata_q <= 64'h0;
			open_row_q <= 11'h000;
		end else begin
			cnt_q <= cnt_q + 4'h1;
			case (st_q)
				S_INIT: begin
					if (wait_done)
						st_q <= S_IDLE;
				end
				S_IDLE: begin
					cnt_q <= 4'h0;
					if (ref_need) begin
						if (cbr_q) begin
							// CAS leads RAS by a full cycle with WE held high
							pins_q.col_strobe_n <= 1'b0;
							st_q <= S_CBR_CAS;
						end else begin
							pins_q.row_strobe_n <= 1'b0;
							pins_q.addr <= ref_row;
							st_q <= S_ROR;
						end
					end else if (accept) begin
						pins_q.row_strobe_n <= 1'b0;
						pins_q.addr <= addr_q[`ADDR_ROW];
						open_row_q <= addr_q[`ADDR_ROW];
						st_q <= S_ROW;
					end
				end
				S_ROW: begin
					pins_q.addr <= {1'b0, addr_q[`ADDR_COL]};
					if (op_q == OP_EWRITE) begin
						// WE low ahead of CAS: the module keeps its outputs off
						pins_q.write_en_n <= 1'b0;
						dq_out_q <= wdata_q;
						dq_oe_q <= 1'b1;
					end
					st_q <= S_COLA;
				end
				S_COLA: begin
					pins_q.col_strobe_n <= 1'b0;
					pins_q.out_en_n <= (op_q == OP_EWRITE);
					cnt_q <= 4'h0;
					st_q <= S_COL;
				end
				S_COL: begin
					if (op_q != OP_EWRITE && cnt_q == 4'(CAP - 1)) begin
						rdata_q <= dq_s2_q;
						pins_q.out_en_n <= 1'b1;
						dq_out_q <= merge_bytes(dq_s2_q, wdata_q, mask_q);
					end
					if (op_q == OP_RMW && cnt_q == 4'(WE_AT - 1)) begin
						// late WE only once read data is in and outputs are off
						pins_q.write_en_n <= 1'b0;
						dq_oe_q <= 1'b1;
					end
					if ((op_q == OP_READ && cnt_q == 4'(CAP - 1)) ||
						(op_q == OP_EWRITE && cnt_q == 4'(EW_END - 1)) ||
						(op_q == OP_RMW && cnt_q == 4'(RMW_END - 1))) begin
						pins_q.col_strobe_n <= 1'b1;
						pins_q.write_en_n <= 1'b1;
						pins_q.out_en_n <= 1'b1;
						dq_oe_q <= 1'b0;
						cnt_q <= 4'h0;
						if (keep_q && !ref_need) begin
							st_q <= S_OPEN;
						end else begin
							pins_q.row_strobe_n <= 1'b1;
							st_q <= S_PRE;
						end
					end
				end
				S_OPEN: begin
					if (accept) begin
						st_q <= S_ROW;
					end else if (ref_need || go_q) begin
						// a due refresh or a new row closes the page
						pins_q.row_strobe_n <= 1'b1;
						cnt_q <= 4'h0;
						st_q <= S_PRE;
					end
				end
				S_CBR_CAS: begin
					pins_q.row_strobe_n <= 1'b0;
					cnt_q <= 4'h0;
					st_q <= S_CBR_RAS;
				end
				S_CBR_RAS, S_ROR: begin
					if (cnt_q == 4'(CHR_CYC - 1))
						pins_q.col_strobe_n <= 1'b1;
					if (ref_done) begin
						pins_q.row_strobe_n <= 1'b1;
						cnt_q <= 4'h0;
						st_q <= S_PRE;
					end
				end
				S_PRE: begin
					if (cnt_q == 4'(RP_CYC - 1))
						st_q <= S_IDLE;
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end

	logic [3:0] since_fall_q, since_rise_q;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			since_fall_q <= 4'hF;
			since_rise_q <= 4'hF;
		end else begin
			since_fall_q <= $fell(pins_q.col_strobe_n) ? 4'h0 :
				(since_fall_q == 4'hF ? 4'hF : since_fall_q + 4'h1);
			since_rise_q <= $rose(pins_q.col_strobe_n) ? 4'h0 :
				(since_rise_q == 4'hF ? 4'hF : since_rise_q + 4'h1);
		end
	end

	early_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(pins_q.col_strobe_n) && !pins_q.write_en_n |->
		$past(!pins_q.write_en_n) && pins_q.out_en_n)
		else $error("early write without WE setup");
	rmw_we_time_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(pins_q.write_en_n) && !pins_q.col_strobe_n |->
		since_fall_q == 4'(WE_AT - 1) && pins_q.out_en_n)
		else $error("late WE at wrong time");
	page_cycle_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(pins_q.col_strobe_n) && !pins_q.row_strobe_n && $past(!pins_q.row_strobe_n) |->
		$past(since_fall_q) >= 4'(PRWC_CYC - 1))
		else $error("page column cycle too short");
	cpw_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(pins_q.write_en_n) && !pins_q.col_strobe_n |->
		$past(since_rise_q) >= 4'(CPW_CYC - 1))
		else $error("WE too soon after CAS precharge");
	cbr_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(pins_q.row_strobe_n) && !pins_q.col_strobe_n |->
		pins_q.write_en_n ##1 pins_q.write_en_n && (st_q == S_CBR_RAS) ##1 pins_q.col_strobe_n)
		else $error("CAS or WE hold in refresh broken");
	cbr_setup_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(pins_q.col_strobe_n) && pins_q.row_strobe_n |->
		$past(pins_q.row_strobe_n, 2) && $past(pins_q.write_en_n) ##1 $fell(pins_q.row_strobe_n))
		else $error("CAS before RAS setup broken");
	init_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(pins_q.row_strobe_n) && !init_done |-> wait_done && !pins_q.out_en_n == 1'b0)
		else $error("access before power-up wait");
	page_close_a: assert property (@(posedge mclk) disable iff (!reset_n)
		st_q == S_OPEN && ref_need |=> pins_q.row_strobe_n && st_q == S_PRE)
		else $error("refresh with open page");

	rmw_c: cover property (@(posedge mclk) disable iff (!reset_n)
		$fell(pins_q.write_en_n) && !pins_q.col_strobe_n);
	page_hit_c: cover property (@(posedge mclk) disable iff (!reset_n)
		st_q == S_OPEN && accept);
	cbr_c: cover property (@(posedge mclk) disable iff (!reset_n) st_q == S_CBR_RAS);
endmodule : dram_host

// ===== core/dram_host_defines.svh
// timing figures, register map and field positions of the module controller
`ifndef DRAM_HOST_DEFINES_SVH
`define DRAM_HOST_DEFINES_SVH

`define CLK_NS 20
`define CYC_MIN(t) (((t) + `CLK_NS - 1) / `CLK_NS)
`define CYC_MAX(t) ((t) / `CLK_NS)

`define COL_SETUP_IN_COL_FIRST_REFRESH_NS 15
`define COL_HOLD_IN_COL_FIRST_REFRESH_NS 18
`define WRITE_SETUP_IN_REFRESH_NS 15
`define WRITE_HOLD_IN_REFRESH_NS 8
`define ROW_PRECHARGE_TO_COL_HOLD_NS 3
`define T_RP_NS 50
`define T_RAS_NS 70
`define T_CAC_NS 25
`define T_OEZ_NS 25
`define T_CWL_NS 22
`define PAGE_RMW_CYCLE_TIME_NS 98
`define WRITE_AFTER_COL_PRECHARGE_DELAY_NS 73
`define T_PD_NS 10
`define INFO_DISABLE_TO_RELEASE_NS 10
`define T_REF_MS 32
`define REF_ROWS 2048
`define T_INIT_US 200
`define INIT_REFS 4'h8
`define SYNC_STAGES 2

`define REF_INT_CYC ((`T_REF_MS * 1000000 / `REF_ROWS) / `CLK_NS)
`define INIT_CYC (`T_INIT_US * 1000 / `CLK_NS)

`define REG_CTRL 3'h0
`define REG_ADDR 3'h1
`define REG_WDLO 3'h2
`define REG_WDHI 3'h3
`define REG_RDLO 3'h4
`define REG_RDHI 3'h5
`define REG_STATUS 3'h6

`define CTRL_GO 0
`define CTRL_OP 2:1
`define CTRL_KEEP 3
`define CTRL_CBR 4
`define CTRL_PD_GO 5
`define CTRL_PD_SLOT 7:6
`define CTRL_MASK 15:8
`define ADDR_ROW 20:10
`define ADDR_COL 9:0

`endif

// ===== core/dram_host_pkg.sv
// types shared by the module controller
package dram_host_pkg;
	typedef enum logic [3:0] {
		S_INIT = 4'h0,
		S_IDLE = 4'h1,
		S_ROW = 4'h2,
		S_COLA = 4'h3,
		S_COL = 4'h4,
		S_OPEN = 4'h5,
		S_PRE = 4'h6,
		S_CBR_CAS = 4'h7,
		S_CBR_RAS = 4'h8,
		S_ROR = 4'h9
	} seq_state_t;

	typedef enum logic [1:0] {
		OP_READ = 2'h0,
		OP_EWRITE = 2'h1,
		OP_RMW = 2'h2
	} op_t;

	typedef enum logic [1:0] {
		PD_IDLE = 2'h0,
		PD_ON = 2'h1,
		PD_OFF = 2'h2
	} pd_state_t;

	typedef struct packed {
		logic row_strobe_n;
		logic col_strobe_n;
		logic write_en_n;
		logic out_en_n;
		logic [10:0] addr;
	} dram_pins_t;
endpackage : dram_host_pkg

// ===== core/presence_reader.sv
// presence-detect read through per-position enables, with synchronised id bits
`timescale 1ns/10ps
`include "dram_host_defines.svh"
module presence_reader import dram_host_pkg::*; (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [1:0] slot,
	input wire logic [7:0] module_info_bits,
	input wire logic [1:0] id_bits,
	output logic [3:0] presence_detect_enable_n,
	output logic [7:0] info,
	output logic [1:0] ids,
	output logic busy
);
	localparam int ON_CYC = `CYC_MIN(`T_PD_NS) + `SYNC_STAGES;
	localparam int OFF_CYC = `CYC_MIN(`INFO_DISABLE_TO_RELEASE_NS);
	pd_state_t st_q;
	logic [1:0] cnt_q;
	logic [3:0] pde_n_q;
	logic [7:0] info_s1_q, info_s2_q, info_q;
	logic [1:0] id_s1_q, id_s2_q;

	assign presence_detect_enable_n = pde_n_q;
	assign info = info_q;
	assign ids = id_s2_q;
	assign busy = (st_q != PD_IDLE);

	// pins come from the module, the pull-ups make an open line read as 1
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			info_s1_q <= 8'hFF;
			info_s2_q <= 8'hFF;
			id_s1_q <= 2'h3;
			id_s2_q <= 2'h3;
		end else begin
			info_s1_q <= module_info_bits;
			info_s2_q <= info_s1_q;
			id_s1_q <= id_bits;
			id_s2_q <= id_s1_q;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= PD_IDLE;
			cnt_q <= 2'h0;
			pde_n_q <= 4'hF;
			info_q <= 8'hFF;
		end else begin
			cnt_q <= cnt_q + 2'h1;
			case (st_q)
				PD_IDLE: begin
					cnt_q <= 2'h0;
					if (start) begin
						// only the chosen position answers on the shared lines
						pde_n_q <= ~(4'h1 << slot);
						st_q <= PD_ON;
					end
				end
				PD_ON: begin
					if (cnt_q == 2'(ON_CYC - 1)) begin
						info_q <= info_s2_q;
						pde_n_q <= 4'hF;
						cnt_q <= 2'h0;
						st_q <= PD_OFF;
					end
				end
				PD_OFF: begin
					// lines must be released before another position is enabled
					if (cnt_q == 2'(OFF_CYC - 1))
						st_q <= PD_IDLE;
				end
				default: st_q <= PD_IDLE;
			endcase
		end
	end

	pd_onehot_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$countones(~pde_n_q) <= 1)
		else $error("two positions enabled at once");
	pd_window_a: assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(busy) |-> $past(pde_n_q) == 4'hF && $past(pde_n_q, 2) != 4'hF)
		else $error("enable window wrong length");
	pd_read_c: cover property (@(posedge mclk) disable iff (!reset_n) $rose(busy));
endmodule : presence_reader

// ===== core/refresh_timer.sv
// refresh interval timer with pending count and row-only refresh row counter
`timescale 1ns/10ps
`include "dram_host_defines.svh"
module refresh_timer import dram_host_pkg::*; (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic done,
	output logic req,
	output logic [10:0] row
);
	localparam int INT_CYC = `REF_INT_CYC;
	logic [9:0] tick_q;
	logic [3:0] pend_q;
	logic [10:0] row_q;
	logic tick;

	assign tick = (tick_q == 10'(INT_CYC - 1));
	assign req = (pend_q != 4'h0);
	assign row = row_q;

	// one request per interval keeps all rows inside the retention window
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tick_q <= 10'h000;
		end else begin
			tick_q <= tick ? 10'h000 : tick_q + 10'h001;
		end
	end

	// saturating backlog so a long access never loses a request
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pend_q <= 4'h0;
		end else if (tick && !(done && req)) begin
			if (pend_q != 4'hF)
				pend_q <= pend_q + 4'h1;
		end else if (!tick && done && req) begin
			pend_q <= pend_q - 4'h1;
		end
	end

	// wraps after the last of the 2048 rows
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			row_q <= 11'h000;
		end else if (done) begin
			row_q <= row_q + 11'h001;
		end
	end

	ref_interval_a: assert property (@(posedge mclk) disable iff (!reset_n)
		tick |-> ##1 (tick_q == 10'h000) ##1 !tick [*8])
		else $error("refresh interval restarted wrongly");
	row_wrap_a: assert property (@(posedge mclk) disable iff (!reset_n)
		done && row_q == 11'h7FF |=> row_q == 11'h000)
		else $error("refresh row did not wrap");
endmodule : refresh_timer

// ===== tb/dram_module_model.sv
// behavioural model of the 2M x 64 memory module with presence-detect outputs
`timescale 1ns/10ps
module dram_module_model import dram_host_pkg::*; #(
	parameter int SLOT = 0,
	parameter logic [7:0] INFO_BITS = 8'hCB
) (
	input wire dram_pins_t pins,
	input wire logic [63:0] dq_out,
	input wire logic dq_oe,
	input wire logic [3:0] presence_detect_enable_n,
	output logic [63:0] dq_in,
	output logic [7:0] module_info_bits,
	output logic width_id,
	output logic style_id
);
	logic [63:0] mem [logic [20:0]];
	logic [10:0] row_q;
	logic [9:0] col_q;
	logic [63:0] last_q;
	logic [63:0] rdata;
	wire [20:0] key = {row_q, col_q};
	// drives only while reading with write enable still high; early write never drives
	wire rd_on = !pins.row_strobe_n && !pins.col_strobe_n && !pins.out_en_n && pins.write_en_n;
	assign rdata = mem.exists(key) ? mem[key] : {43'h0, key};
	// released bus shows the inverse of its last value, never a stale copy
	assign #5 dq_in = rd_on ? rdata : ~last_q;
	always @(rdata, rd_on) begin
		if (rd_on) last_q = rdata;
	end
	initial last_q = 64'h0;
	always @(negedge pins.row_strobe_n) begin
		if (pins.col_strobe_n) row_q = pins.addr;
	end
	always @(negedge pins.col_strobe_n) begin
		if (!pins.row_strobe_n) begin
			col_q = pins.addr[9:0];
			if (!pins.write_en_n) mem[{row_q, pins.addr[9:0]}] = dq_out;
		end
	end
	always @(negedge pins.write_en_n) begin
		if (!pins.col_strobe_n && !pins.row_strobe_n) mem[key] = dq_out;
	end
	// open bits read as 1 through the board pull-ups; strobes play no part
	assign #5 module_info_bits = presence_detect_enable_n[SLOT] ? 8'hFF : INFO_BITS;
	assign width_id = 1'b0;
	assign style_id = 1'b0;
endmodule : dram_module_model

// ===== tb/tb_top.sv
// self-checking bench for the module host controller
`timescale 1ns/10ps
`include "dram_host_defines.svh"
module tb_top import dram_host_pkg::*;;
	logic mclk, reset_n, avs_read, avs_write, avs_waitrequest, dq_oe, width_id, style_id;
	logic [2:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [63:0] dq_in, dq_out;
	logic [3:0] pde_n;
	logic [7:0] info;
	logic [10:0] ror_prev, ror_last;
	logic we_at_cas;
	time cas_fall_t = 0, cas_rise_t = 0, ras_fall_t = 0, ras_rise_t = 0;
	dram_pins_t dram;
	int n_errors = 0, checks = 0, cbr_cnt = 0, ror_cnt = 0;
	dram_host #(.INIT_CYC(20)) dut (.mclk(mclk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dram(dram),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .presence_detect_enable_n(pde_n),
		.module_info_bits(info), .bank_width_id_bit(width_id), .refresh_style_id_bit(style_id));
	dram_module_model model (.pins(dram), .dq_out(dq_out), .dq_oe(dq_oe),
		.presence_detect_enable_n(pde_n), .dq_in(dq_in), .module_info_bits(info),
		.width_id(width_id), .style_id(style_id));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(negedge dram.row_strobe_n) begin
		if (dram.col_strobe_n === 1'b0) begin
			cbr_cnt++;
			check($time - cas_fall_t >= 15, 1'b1, "refresh col setup");
			check(cas_fall_t - ras_rise_t >= 3, 1'b1, "col precharge hold");
			check(dram.write_en_n, 1'b1, "refresh write enable");
		end else begin
			ror_prev = ror_last;
			ror_last = dram.addr;
			ror_cnt++;
		end
		ras_fall_t = $time;
	end
	always @(posedge dram.row_strobe_n) begin
		ras_rise_t = $time;
	end
	always @(negedge dram.col_strobe_n) begin
		if (dram.row_strobe_n === 1'b0) begin
			we_at_cas = dram.write_en_n;
			// a second column fall under one row strobe is a page cycle
			if (cas_fall_t > ras_fall_t)
				check($time - cas_fall_t >= 98, 1'b1, "page column cycle");
		end
		cas_fall_t = $time;
	end
	always @(posedge dram.col_strobe_n) begin
		if (dram.row_strobe_n === 1'b0 && ras_fall_t > cas_fall_t)
			check($time - ras_fall_t >= 18, 1'b1, "refresh col hold");
		cas_rise_t = $time;
	end
	always @(negedge dram.write_en_n) begin
		if (dram.col_strobe_n === 1'b0 && cas_rise_t > ras_fall_t)
			check($time - cas_rise_t >= 73, 1'b1, "write after col precharge");
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		if (wr) avs_write <= 1'b1;
		else avs_read <= 1'b1;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0 && n < 100) begin
			@(posedge mclk);
			n++;
		end
		rd = avs_readdata;
		check(n < 100, 1'b1, "bus answer");
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask : bus
	task automatic wait_status(input int b, input logic v);
		int n;
		n = 0;
		bus(1'b0, `REG_STATUS, 32'h0);
		while (rd[b] !== v && n < 500) begin
			bus(1'b0, `REG_STATUS, 32'h0);
			n++;
		end
		check(n < 500, 1'b1, "status wait");
	endtask : wait_status
	task automatic t_reset;
		check(avs_waitrequest, 1'b1, "waitrequest in reset");
		check({dram.row_strobe_n, dram.col_strobe_n, dram.write_en_n, dram.out_en_n}, 4'hF, "strobes");
		check({dq_oe, pde_n}, 5'h0F, "data and enables in reset");
		$display("reset test done");
	endtask : t_reset
	task automatic t_init;
		wait_status(1, 1'b1);
		check(cbr_cnt >= 8, 1'b1, "refreshes before ready");
		bus(1'b0, 3'h7, 32'h0);
		check(rd, 32'h0, "unmapped read");
		$display("init test done");
	endtask : t_init
	task automatic access(input logic [31:0] ctrl, input logic [63:0] wd);
		bus(1'b1, `REG_ADDR, 32'h0000_1409);
		bus(1'b1, `REG_WDLO, wd[31:0]);
		bus(1'b1, `REG_WDHI, wd[63:32]);
		bus(1'b1, `REG_CTRL, ctrl);
		wait_status(0, 1'b0);
	endtask : access
	task automatic read_back(input logic [63:0] exp);
		// page is left open so the next access runs as a page hit
		access(32'h0000_FF19, 64'h0);
		check(we_at_cas, 1'b1, "read write enable");
		bus(1'b0, `REG_RDLO, 32'h0);
		check(rd, exp[31:0], "read low");
		bus(1'b0, `REG_RDHI, 32'h0);
		check(rd, exp[63:32], "read high");
	endtask : read_back
	task automatic t_write_rmw;
		access(32'h0000_FF13, 64'h0123_4567_89AB_CDEF);
		check(we_at_cas, 1'b0, "early write enable");
		read_back(64'h0123_4567_89AB_CDEF);
		access(32'h0000_0F15, 64'hFEDC_BA98_7654_3210);
		check(we_at_cas, 1'b1, "late write enable");
		read_back(64'h0123_4567_7654_3210);
		$display("write and merge test done");
	endtask : t_write_rmw
	task automatic t_presence;
		bus(1'b1, `REG_CTRL, 32'h0000_FF30);
		wait_status(3, 1'b0);
		check(rd[23:16], 8'hCB, "info bits");
		check(rd[4], 1'b1, "bank is 64 bit");
		check(rd[9:8], 2'h0, "id bits");
		check(pde_n, 4'hF, "enables released");
		bus(1'b1, `REG_CTRL, 32'h0000_FF70);
		wait_status(3, 1'b0);
		check(rd[23:16], 8'hFF, "empty position");
		$display("presence test done");
	endtask : t_presence
	task automatic t_refresh;
		int start;
		start = cbr_cnt;
		repeat (4000) @(posedge mclk);
		check((cbr_cnt - start) inside {5, 6}, 1'b1, "refresh rate");
		// a write landing while a refresh runs is dropped, so retry it
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, `REG_CTRL, 32'h0000_FF00);
			bus(1'b0, `REG_CTRL, 32'h0);
			if (!rd[4])
				break;
		end
		check(rd[4], 1'b0, "row-only mode selected");
		ror_cnt = 0;
		repeat (2400) @(posedge mclk);
		check(ror_cnt >= 2, 1'b1, "row-only refreshes");
		check(ror_last, ror_prev + 11'h1, "row counter step");
		$display("refresh test done");
	endtask : t_refresh
	task automatic end_sim;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (20000) @(posedge mclk);
		n_errors++;
		$display("wrong value at %0t: watchdog", $time);
		end_sim();
	end
	initial begin
		reset_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 3'h0;
		avs_writedata = 32'h0;
		repeat (2) @(posedge mclk);
		t_reset();
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		t_init();
		t_write_rmw();
		t_presence();
		t_refresh();
		end_sim();
	end
endmodule : tb_top
